// ==== logic/pae_pkg.sv ====
// Purpose: Shared constants for the process alarm evaluator.
// Assumes: 100 MHz clock; values are signed engineering units.
// Notes: Type codes follow the alarm type selector of each channel.
// Functional notes
// (RL1) Per-channel type; resets to upper-limit; 0 disables.
// (RL2) ON and OFF delays, 0 to 999 s.
// (RL3) Heater variant: channel 1 is heater alarm.
// (RL4) Code 1: alarm outside set point band.
// (RL5) Code 2: value exceeds set point by threshold.
// (RL6) Code 3: value below set point by threshold.
// (RL7) Code 4: alarm inside set point band.
// (RL8) Codes 5-7: codes 1-3 with standby.
// (RL9) Code 8: process value above threshold.
// (RL10) Code 9: process value below threshold.
// (RL11) Codes 10-11: codes 8-9 with standby.
// (RL12) Code 12: loop break, channel 1 only.
// (RL13) Code 13: process value rate-of-change alarm.
// (RL14) Code 14: set point above threshold.
// (RL15) Code 15: set point below threshold.
// (RL16) Code 16: manipulated variable above threshold.
// (RL17) Code 17: manipulated variable below threshold.
// (RL18) Heat/cool, negative threshold: output alarm always on.
// (RL19) Heat/cool: upper uses heating, lower cooling output.
// (RL20) Upper and bottom deviations programmed separately.
// (RL21) Code 5 off while hysteresis bands overlap.
// (RL22) Evaluate once per input sampling period.
// (RL23) Standby holds off until condition first false.
// (RL24) ON/OFF delays filter the raw condition.
// (RL25) Release only past threshold by hysteresis.
package pae_pkg;
  localparam int NUM_CH = 3;
  localparam int VAL_W = 16;
  localparam int EXT_W = VAL_W + 2;
  localparam int TYPE_W = 5;
  localparam int DLY_W = 10;
  localparam int SMP_W = 23;
  localparam int SEC_W = 5;
  localparam logic [TYPE_W-1:0] T_OFF = 5'h00;
  localparam logic [TYPE_W-1:0] T_BAND_OUT = 5'h01;
  localparam logic [TYPE_W-1:0] T_DEV_HI = 5'h02;
  localparam logic [TYPE_W-1:0] T_DEV_LO = 5'h03;
  localparam logic [TYPE_W-1:0] T_BAND_IN = 5'h04;
  localparam logic [TYPE_W-1:0] T_BAND_OUT_SB = 5'h05;
  localparam logic [TYPE_W-1:0] T_DEV_HI_SB = 5'h06;
  localparam logic [TYPE_W-1:0] T_DEV_LO_SB = 5'h07;
  localparam logic [TYPE_W-1:0] T_ABS_HI = 5'h08;
  localparam logic [TYPE_W-1:0] T_ABS_LO = 5'h09;
  localparam logic [TYPE_W-1:0] T_ABS_HI_SB = 5'h0a;
  localparam logic [TYPE_W-1:0] T_ABS_LO_SB = 5'h0b;
  localparam logic [TYPE_W-1:0] T_LOOP_BREAK = 5'h0c;
  localparam logic [TYPE_W-1:0] T_RATE = 5'h0d;
  localparam logic [TYPE_W-1:0] T_SETP_HI = 5'h0e;
  localparam logic [TYPE_W-1:0] T_SETP_LO = 5'h0f;
  localparam logic [TYPE_W-1:0] T_MANIP_HI = 5'h10;
  localparam logic [TYPE_W-1:0] T_MANIP_LO = 5'h11;
  localparam logic [TYPE_W-1:0] TYPE_RESET = T_DEV_HI;
  localparam int LOOP_BREAK_CH = 0;
  localparam int HEATER_CH = 0;
  localparam logic [DLY_W-1:0] DLY_MAX_S = 10'h3e7;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_NS = 50_000_000;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLES_PER_SEC = SECOND_NS / SAMPLE_PERIOD_NS;
endpackage : pae_pkg

// ==== logic/pae_delay.sv ====
// Purpose: ON/OFF delay filter for one alarm channel.
// Assumes: sec_tick is a one-cycle pulse once per second.
// Notes: The first second may be short, as ticks run free.
`timescale 1ns/10ps
module pae_delay (
  input wire logic clock, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic sec_tick, // One pulse per second.
  input wire logic cond, // Raw alarm condition.
  input wire logic [pae_pkg::DLY_W-1:0] on_delay, // Seconds.
  input wire logic [pae_pkg::DLY_W-1:0] off_delay, // Seconds.
  output logic out_q // Filtered alarm.
);
  import pae_pkg::*;

  logic [DLY_W-1:0] cnt_q;
  logic [DLY_W-1:0] on_lim;
  logic [DLY_W-1:0] off_lim;
  logic [DLY_W-1:0] target;

  // Out-of-range settings saturate rather than wrap.
  assign on_lim = (on_delay > DLY_MAX_S) ? DLY_MAX_S : on_delay; // RL2
  assign off_lim = (off_delay > DLY_MAX_S) ? DLY_MAX_S : off_delay; // RL2
  assign target = cond ? on_lim : off_lim;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (cond == out_q) begin
      cnt_q <= '0; // RL24
    end else if (cnt_q >= target) begin
      out_q <= cond; // RL24
      cnt_q <= '0;
    end else if (sec_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_on_wait;
    $rose(out_q) |-> $past(cnt_q) >= $past(on_lim);
  endproperty
  a_on_wait: assert property (p_on_wait) // RL24
    else $error("Alarm switched on before its ON delay.");

  property p_off_wait;
    $fell(out_q) |-> $past(cnt_q) >= $past(off_lim);
  endproperty
  a_off_wait: assert property (p_off_wait) // RL2
    else $error("Alarm switched off before its OFF delay.");
endmodule : pae_delay

// ==== logic/pae_evaluator.sv ====
// Purpose: Alarm evaluation for all channels of the controller.
// Assumes: Inputs come from logic on the same clock.
// Notes: Comparisons run once per sampling period.
`timescale 1ns/10ps
module pae_evaluator #(
  parameter int unsigned SAMPLE_CYCLES = pae_pkg::SAMPLE_CYCLES_DEF
) (
  input wire logic clock, // System clock, 100 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [pae_pkg::VAL_W-1:0] process_value, // Signed.
  input wire logic [pae_pkg::VAL_W-1:0] set_point, // Signed.
  input wire logic [pae_pkg::VAL_W-1:0] heat_manip, // Heating output.
  input wire logic [pae_pkg::VAL_W-1:0] cool_manip, // Cooling output.
  input wire logic heat_cool_mode, // Heating/cooling control.
  input wire logic [pae_pkg::NUM_CH-1:0] type_wr_en, // Type write.
  input wire logic [pae_pkg::TYPE_W-1:0] type_wr_data, // New type.
  input wire logic [pae_pkg::NUM_CH-1:0][pae_pkg::VAL_W-1:0]
    alarm_value, // Threshold X, signed.
  input wire logic [pae_pkg::NUM_CH-1:0][pae_pkg::VAL_W-1:0]
    upper_dev, // Band upper deviation H.
  input wire logic [pae_pkg::NUM_CH-1:0][pae_pkg::VAL_W-1:0]
    lower_dev, // Band bottom deviation L.
  input wire logic [pae_pkg::NUM_CH-1:0][pae_pkg::VAL_W-1:0]
    hysteresis, // Release margin.
  input wire logic [pae_pkg::NUM_CH-1:0][pae_pkg::DLY_W-1:0]
    on_delay, // ON delay, seconds.
  input wire logic [pae_pkg::NUM_CH-1:0][pae_pkg::DLY_W-1:0]
    off_delay, // OFF delay, seconds.
  input wire logic restart, // Restart pulse, re-arms standby.
  input wire logic heater_variant, // Heater alarm fitted.
  input wire logic assign_alarm1, // Output assigned to alarm 1.
  input wire logic heater_alarm, // Heater alarm condition.
  input wire logic loop_break_alarm, // Loop break condition.
  input wire logic rate_alarm, // Rate-of-change condition.
  output logic [pae_pkg::NUM_CH-1:0] alarm_out_q, // Alarm outputs.
  output logic [pae_pkg::NUM_CH-1:0][pae_pkg::TYPE_W-1:0]
    type_q, // Current type codes.
  output logic [pae_pkg::NUM_CH-1:0] standby_q, // Standby active.
  output logic sample_q // Evaluation strobe.
);
  import pae_pkg::*;

  logic [SMP_W-1:0] smp_cnt_q;
  logic [SEC_W-1:0] sec_cnt_q;
  logic sec_tick_q;
  logic heater_mode;
  logic [NUM_CH-1:0] hi_q;
  logic [NUM_CH-1:0] lo_q;
  logic [NUM_CH-1:0] hi_d;
  logic [NUM_CH-1:0] lo_d;
  logic [NUM_CH-1:0] raw_d;
  logic [NUM_CH-1:0] cond_q;
  logic [NUM_CH-1:0] ovl;
  logic [NUM_CH-1:0] sb_type;
  logic [NUM_CH-1:0] dly_out;
  logic signed [EXT_W-1:0] proc_x;
  logic signed [EXT_W-1:0] setp_x;
  logic signed [EXT_W-1:0] mvh_x;
  logic signed [EXT_W-1:0] mvc_x;

  function automatic logic signed [EXT_W-1:0] sx(
    input logic signed [VAL_W-1:0] v);
    sx = EXT_W'(v);
  endfunction : sx

  // Upward comparison; once held, it needs hys margin to let go.
  function automatic logic over_thr(
    input logic signed [EXT_W-1:0] q,
    input logic signed [EXT_W-1:0] thr,
    input logic signed [EXT_W-1:0] hys,
    input logic held,
    input logic strict);
    if (held) begin
      over_thr = strict ? q > (thr - hys) : q >= (thr - hys); // RL25
    end else if (strict) begin
      over_thr = q > thr;
    end else begin
      over_thr = q >= thr;
    end
  endfunction : over_thr

  function automatic logic under_thr(
    input logic signed [EXT_W-1:0] q,
    input logic signed [EXT_W-1:0] thr,
    input logic signed [EXT_W-1:0] hys,
    input logic held,
    input logic strict);
    if (held) begin
      under_thr = strict ? q < (thr + hys) : q <= (thr + hys); // RL25
    end else if (strict) begin
      under_thr = q < thr;
    end else begin
      under_thr = q <= thr;
    end
  endfunction : under_thr

  assign proc_x = sx(process_value);
  assign setp_x = sx(set_point);
  assign mvh_x = sx(heat_manip);
  assign mvc_x = sx(cool_manip);
  // The heater function hides channel 1 until software reassigns it.
  assign heater_mode = heater_variant && !assign_alarm1; // RL3

  // Sampling period timer and the one-second tick derived from it.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      smp_cnt_q <= '0;
      sample_q <= 1'b0;
    end else if (smp_cnt_q >= SMP_W'(SAMPLE_CYCLES - 1)) begin
      smp_cnt_q <= '0;
      sample_q <= 1'b1; // RL22
    end else begin
      smp_cnt_q <= smp_cnt_q + 1'b1;
      sample_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sec_cnt_q <= '0;
      sec_tick_q <= 1'b0;
    end else if (!sample_q) begin
      sec_tick_q <= 1'b0;
    end else if (sec_cnt_q >= SEC_W'(SAMPLES_PER_SEC - 1)) begin
      sec_cnt_q <= '0;
      sec_tick_q <= 1'b1;
    end else begin
      sec_cnt_q <= sec_cnt_q + 1'b1;
      sec_tick_q <= 1'b0;
    end
  end

  // Type selectors; illegal codes leave the old type in place.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      type_q <= {NUM_CH{TYPE_RESET}}; // RL1
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (type_wr_en[c] && type_wr_data <= T_MANIP_LO
            && !(type_wr_data == T_LOOP_BREAK && c != LOOP_BREAK_CH)
            && !(c == HEATER_CH && heater_mode)) begin
          type_q[c] <= type_wr_data; // RL12
        end
      end
    end
  end

  // Raw evaluation of every channel against its selected type.
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      hi_d[c] = 1'b0;
      lo_d[c] = 1'b0;
      raw_d[c] = 1'b0;
      // Bands overlap when released edges cross each other.
      ovl[c] = (setp_x + sx(upper_dev[c]) - sx(hysteresis[c]))
               <= (setp_x - sx(lower_dev[c]) + sx(hysteresis[c]));
      sb_type[c] = (type_q[c] == T_BAND_OUT_SB)
                   || (type_q[c] == T_DEV_HI_SB)
                   || (type_q[c] == T_DEV_LO_SB)
                   || (type_q[c] == T_ABS_HI_SB)
                   || (type_q[c] == T_ABS_LO_SB); // RL8 RL11
      case (type_q[c])
        T_BAND_OUT, T_BAND_IN, T_BAND_OUT_SB: begin
          hi_d[c] = over_thr(proc_x, setp_x + sx(upper_dev[c]),
                             sx(hysteresis[c]), hi_q[c], 1'b0); // RL20
          lo_d[c] = under_thr(proc_x, setp_x - sx(lower_dev[c]),
                              sx(hysteresis[c]), lo_q[c], 1'b0); // RL20
          if (type_q[c] == T_BAND_IN) begin
            raw_d[c] = !(hi_d[c] || lo_d[c]); // RL7
          end else if (type_q[c] == T_BAND_OUT_SB && ovl[c]) begin
            raw_d[c] = 1'b0; // RL21
          end else begin
            raw_d[c] = hi_d[c] || lo_d[c]; // RL4
          end
        end
        T_DEV_HI, T_DEV_HI_SB: begin
          hi_d[c] = over_thr(proc_x, setp_x + sx(alarm_value[c]),
                             sx(hysteresis[c]), hi_q[c], 1'b0); // RL5
          raw_d[c] = hi_d[c];
        end
        T_DEV_LO, T_DEV_LO_SB: begin
          lo_d[c] = under_thr(proc_x, setp_x - sx(alarm_value[c]),
                              sx(hysteresis[c]), lo_q[c], 1'b0); // RL6
          raw_d[c] = lo_d[c];
        end
        T_ABS_HI, T_ABS_HI_SB: begin
          hi_d[c] = over_thr(proc_x, sx(alarm_value[c]),
                             sx(hysteresis[c]), hi_q[c], 1'b1); // RL9
          raw_d[c] = hi_d[c];
        end
        T_ABS_LO, T_ABS_LO_SB: begin
          lo_d[c] = under_thr(proc_x, sx(alarm_value[c]),
                              sx(hysteresis[c]), lo_q[c], 1'b1); // RL10
          raw_d[c] = lo_d[c];
        end
        T_LOOP_BREAK: begin
          raw_d[c] = loop_break_alarm; // RL12
        end
        T_RATE: begin
          raw_d[c] = rate_alarm; // RL13
        end
        T_SETP_HI: begin
          hi_d[c] = over_thr(setp_x, sx(alarm_value[c]),
                             sx(hysteresis[c]), hi_q[c], 1'b1); // RL14
          raw_d[c] = hi_d[c];
        end
        T_SETP_LO: begin
          lo_d[c] = under_thr(setp_x, sx(alarm_value[c]),
                              sx(hysteresis[c]), lo_q[c], 1'b1); // RL15
          raw_d[c] = lo_d[c];
        end
        T_MANIP_HI: begin
          hi_d[c] = over_thr(mvh_x, sx(alarm_value[c]),
                             sx(hysteresis[c]), hi_q[c], 1'b1); // RL16 RL19
          raw_d[c] = hi_d[c]
            || (heat_cool_mode && sx(alarm_value[c]) < 0); // RL18
        end
        T_MANIP_LO: begin
          lo_d[c] = under_thr(heat_cool_mode ? mvc_x : mvh_x,
                              sx(alarm_value[c]), sx(hysteresis[c]),
                              lo_q[c], 1'b1); // RL17 RL19
          raw_d[c] = lo_d[c]
            || (heat_cool_mode && sx(alarm_value[c]) < 0); // RL18
        end
        default: begin
          raw_d[c] = 1'b0; // RL1
        end
      endcase
    end
  end

  // Comparator memories and the gated condition move only on samples.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_q <= '0;
      lo_q <= '0;
      cond_q <= '0;
    end else if (sample_q) begin
      hi_q <= hi_d; // RL22
      lo_q <= lo_d;
      cond_q <= raw_d & ~(sb_type & standby_q); // RL23
    end
  end

  // Standby arms at reset and restart; a restart beats a release.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      standby_q <= '1;
    end else if (restart) begin
      standby_q <= '1; // RL23
    end else if (sample_q) begin
      standby_q <= standby_q & raw_d; // RL23
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_dly
    pae_delay u_delay (
      .clock(clock),
      .resetn(resetn),
      .sec_tick(sec_tick_q),
      .cond(cond_q[g]),
      .on_delay(on_delay[g]),
      .off_delay(off_delay[g]),
      .out_q(dly_out[g])
    );
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alarm_out_q <= '0;
    end else begin
      alarm_out_q <= dly_out;
      if (heater_mode) begin
        alarm_out_q[HEATER_CH] <= heater_alarm; // RL3
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_eval(logic [TYPE_W-1:0] t);
    sample_q && type_q[1] == t;
  endsequence

  property p_type_off;
    s_eval(T_OFF) |=> !cond_q[1];
  endproperty
  a_type_off: assert property (p_type_off) // RL1
    else $error("Disabled alarm raised its condition.");

  property p_brk_ch;
    type_wr_en[1] && type_wr_data == T_LOOP_BREAK
      |=> type_q[1] != T_LOOP_BREAK;
  endproperty
  a_brk_ch: assert property (p_brk_ch) // RL12
    else $error("Loop break type accepted off channel 1.");

  property p_abs_hi;
    s_eval(T_ABS_HI) ##0 (proc_x > sx(alarm_value[1])) |=> cond_q[1];
  endproperty
  a_abs_hi: assert property (p_abs_hi) // RL9
    else $error("Absolute upper alarm missed.");

  property p_abs_lo;
    s_eval(T_ABS_LO) ##0 (proc_x < sx(alarm_value[1])) |=> cond_q[1];
  endproperty
  a_abs_lo: assert property (p_abs_lo) // RL10
    else $error("Absolute lower alarm missed.");

  property p_sp_hi;
    s_eval(T_SETP_HI) ##0 (setp_x > sx(alarm_value[1])) |=> cond_q[1];
  endproperty
  a_sp_hi: assert property (p_sp_hi) // RL14
    else $error("Set point upper alarm missed.");

  property p_neg_heat;
    s_eval(T_MANIP_HI) ##0 (heat_cool_mode && sx(alarm_value[1]) < 0)
      |=> cond_q[1];
  endproperty
  a_neg_heat: assert property (p_neg_heat) // RL18
    else $error("Negative heating output alarm not forced on.");

  sequence s_restart;
    restart ##1 (&standby_q);
  endsequence

  property p_rearm;
    restart |-> s_restart;
  endproperty
  a_rearm: assert property (p_rearm) // RL23
    else $error("Restart did not re-arm standby.");

  property p_standby;
    s_eval(T_DEV_HI_SB) ##0 standby_q[1] |=> !cond_q[1];
  endproperty
  a_standby: assert property (p_standby) // RL23
    else $error("Standby alarm raised before release.");

  property p_overlap;
    s_eval(T_BAND_OUT_SB) ##0 ovl[1] |=> !cond_q[1];
  endproperty
  a_overlap: assert property (p_overlap) // RL21
    else $error("Overlapping band alarm raised.");

  property p_heater;
    heater_mode |=> alarm_out_q[HEATER_CH] == $past(heater_alarm);
  endproperty
  a_heater: assert property (p_heater) // RL3
    else $error("Heater alarm not routed to channel 1.");
endmodule : pae_evaluator

// ==== verif/pae_loop_model.sv ====
// Purpose: Measurement loop feeding the alarm evaluator.
// Assumes: One fresh reading is taken per evaluation strobe.
// Notes: Readings move only after a strobe, as the real loop does.
`timescale 1ns/10ps
module pae_loop_model (
  input wire logic clock, // System clock.
  input wire logic sample, // Evaluation strobe.
  input wire logic [15:0] proc_next, // Next process value.
  input wire logic [15:0] setp_next, // Next set point.
  input wire logic [15:0] mvh_next, // Next heating MV.
  input wire logic [15:0] mvc_next, // Next cooling MV.
  output logic [15:0] process_value = 16'h0000, // To evaluator.
  output logic [15:0] set_point = 16'h0000, // To evaluator.
  output logic [15:0] heat_manip = 16'h0000, // To evaluator.
  output logic [15:0] cool_manip = 16'h0000 // To evaluator.
);
  // A reading changing mid-period would never be seen, so hold it.
  always_ff @(posedge clock) begin
    if (sample) begin
      process_value <= proc_next;
      set_point <= setp_next;
      heat_manip <= mvh_next;
      cool_manip <= mvc_next;
    end
  end
endmodule : pae_loop_model

// ==== verif/test_process_alarm_evaluator.sv ====
// Purpose: Self-checking bench for the process alarm evaluator.
// Assumes: SAMPLE_CYCLES of 10, so one second is 200 clocks.
// Notes: Channel index 1 carries most cases; a reset precedes each.
`timescale 1ns/10ps
module test_process_alarm_evaluator;
  import pae_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] proc_next = 16'h0000, setp_next = 16'h0000;
  logic [15:0] mvh_next = 16'h0000, mvc_next = 16'h0000;
  logic [VAL_W-1:0] process_value, set_point, heat_manip, cool_manip;
  logic heat_cool_mode = 1'b0, restart = 1'b0, heater_variant = 1'b0;
  logic assign_alarm1 = 1'b0, heater_alarm = 1'b0;
  logic loop_break_alarm = 1'b0, rate_alarm = 1'b0;
  logic [NUM_CH-1:0] type_wr_en = '0;
  logic [TYPE_W-1:0] type_wr_data = 5'h00;
  logic [NUM_CH-1:0][VAL_W-1:0] alarm_value = '0, upper_dev = '0;
  logic [NUM_CH-1:0][VAL_W-1:0] lower_dev = '0, hysteresis = '0;
  logic [NUM_CH-1:0][DLY_W-1:0] on_delay = '0, off_delay = '0;
  logic [NUM_CH-1:0] alarm_out_q, standby_q;
  logic [NUM_CH-1:0][TYPE_W-1:0] type_q;
  logic sample_q;
  int n_fail = 0, n_tests = 0, cyc = 0;

  always #5 clock = ~clock;

  pae_loop_model u_loop (.clock(clock), .sample(sample_q),
    .proc_next(proc_next), .setp_next(setp_next), .mvh_next(mvh_next),
    .mvc_next(mvc_next), .process_value(process_value),
    .set_point(set_point), .heat_manip(heat_manip),
    .cool_manip(cool_manip));

  pae_evaluator #(.SAMPLE_CYCLES(10)) u_dut (.clock(clock),
    .resetn(resetn), .process_value(process_value),
    .set_point(set_point), .heat_manip(heat_manip),
    .cool_manip(cool_manip),
    .heat_cool_mode(heat_cool_mode), .type_wr_en(type_wr_en),
    .type_wr_data(type_wr_data), .alarm_value(alarm_value),
    .upper_dev(upper_dev), .lower_dev(lower_dev),
    .hysteresis(hysteresis), .on_delay(on_delay),
    .off_delay(off_delay), .restart(restart),
    .heater_variant(heater_variant), .assign_alarm1(assign_alarm1),
    .heater_alarm(heater_alarm), .loop_break_alarm(loop_break_alarm),
    .rate_alarm(rate_alarm), .alarm_out_q(alarm_out_q),
    .type_q(type_q), .standby_q(standby_q), .sample_q(sample_q));

  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // A hung design must still reach the closing report.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wait_smp;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (sample_q === 1'b1) return;
    end
    check(1'b0, 1'b1);
  endtask : wait_smp

  // One strobe lets the loop take the reading, the next evaluates it.
  task automatic settle;
    wait_smp();
    wait_smp();
    tick(4);
  endtask : settle

  task automatic do_reset;
    resetn = 1'b0;
    tick(16);
    resetn = 1'b1;
    tick(1);
  endtask : do_reset

  task automatic wr_type(input int ch, input logic [4:0] code);
    type_wr_en = 3'h1 << ch;
    type_wr_data = code;
    tick(1);
    type_wr_en = 3'h0;
    tick(1);
  endtask : wr_type

  task automatic run_case(input logic [4:0] code, input logic [15:0] pval,
      input logic [15:0] sval, input logic [15:0] x, input logic exp);
    do_reset();
    wr_type(1, code);
    proc_next = pval;
    setp_next = sval;
    alarm_value[1] = x;
    settle();
    check(alarm_out_q[1], exp);
  endtask : run_case

  // The loop keeps its reading over a reset; a stale one could release
  // standby early, so the case's own reading is loaded first.
  task automatic sb_case(input logic [4:0] code, input logic [15:0] on_val,
      input logic [15:0] off_val, input logic [15:0] x);
    setp_next = 16'h0032;
    alarm_value[1] = x;
    proc_next = on_val;
    settle();
    do_reset();
    wr_type(1, code);
    settle();
    check(alarm_out_q[1], 1'b0);
    check(standby_q[1], 1'b1);
    proc_next = off_val;
    settle();
    proc_next = on_val;
    settle();
    check(alarm_out_q[1], 1'b1);
    check(standby_q[1], 1'b0);
    restart = 1'b1;
    tick(1);
    restart = 1'b0;
    settle();
    check(alarm_out_q[1], 1'b0);
    $display("standby case %h done", code);
  endtask : sb_case

  task automatic test_reset_strobe;
    check(type_q, 15'h0842);
    check(standby_q, 3'h7);
    check(alarm_out_q, 3'h0);
    wait_smp();
    wait_smp();
    tick(9);
    check(sample_q, 1'b0);
    tick(1);
    check(sample_q, 1'b1);
    $display("reset and strobe test done");
  endtask : test_reset_strobe

  task automatic test_types;
    upper_dev[1] = 16'h000a;
    lower_dev[1] = 16'h000a;
    run_case(5'h00, 16'h0064, 16'h0000, 16'h0000, 1'b0);
    run_case(5'h01, 16'h0064, 16'h0032, 16'h0000, 1'b1);
    run_case(5'h01, 16'h0032, 16'h0032, 16'h0000, 1'b0);
    run_case(5'h04, 16'h0032, 16'h0032, 16'h0000, 1'b1);
    run_case(5'h04, 16'h0064, 16'h0032, 16'h0000, 1'b0);
    run_case(5'h02, 16'h003c, 16'h0032, 16'h000a, 1'b1);
    run_case(5'h02, 16'h0037, 16'h0032, 16'h000a, 1'b0);
    run_case(5'h03, 16'h0028, 16'h0032, 16'h000a, 1'b1);
    run_case(5'h03, 16'h002d, 16'h0032, 16'h000a, 1'b0);
    run_case(5'h08, 16'h001e, 16'h0000, 16'h001e, 1'b0);
    run_case(5'h08, 16'h001f, 16'h0000, 16'h001e, 1'b1);
    run_case(5'h09, 16'h001d, 16'h0000, 16'h001e, 1'b1);
    run_case(5'h09, 16'h001e, 16'h0000, 16'h001e, 1'b0);
    run_case(5'h0e, 16'h0000, 16'h001f, 16'h001e, 1'b1);
    run_case(5'h0e, 16'h0000, 16'h001e, 16'h001e, 1'b0);
    run_case(5'h0f, 16'h0000, 16'h001d, 16'h001e, 1'b1);
    mvh_next = 16'h001f;
    run_case(5'h10, 16'h0000, 16'h0000, 16'h001e, 1'b1);
    mvh_next = 16'h001d;
    run_case(5'h11, 16'h0000, 16'h0000, 16'h001e, 1'b1);
    run_case(5'h10, 16'h0000, 16'h0000, 16'h001e, 1'b0);
    heat_cool_mode = 1'b1;
    mvh_next = 16'hff9c;
    mvc_next = 16'h0064;
    run_case(5'h10, 16'h0000, 16'h0000, 16'hfffb, 1'b1);
    run_case(5'h11, 16'h0000, 16'h0000, 16'hfffb, 1'b1);
    mvh_next = 16'h0064;
    mvc_next = 16'h001d;
    run_case(5'h11, 16'h0000, 16'h0000, 16'h001e, 1'b1);
    mvh_next = 16'h001d;
    mvc_next = 16'h0064;
    run_case(5'h10, 16'h0000, 16'h0000, 16'h001e, 1'b0);
    heat_cool_mode = 1'b0;
    lower_dev[1] = 16'h001e;
    run_case(5'h01, 16'h0019, 16'h0032, 16'h0000, 1'b0);
    run_case(5'h01, 16'h000f, 16'h0032, 16'h0000, 1'b1);
    lower_dev[1] = 16'h0002;
    upper_dev[1] = 16'h0002;
    hysteresis[1] = 16'h0005;
    run_case(5'h05, 16'h0064, 16'h0032, 16'h0000, 1'b0);
    hysteresis[1] = 16'h0000;
    proc_next = 16'h0032;
    settle();
    check(standby_q[1], 1'b0);
    hysteresis[1] = 16'h0005;
    proc_next = 16'h0064;
    settle();
    check(alarm_out_q[1], 1'b0);
    upper_dev[1] = 16'h000a;
    lower_dev[1] = 16'h000a;
    hysteresis[1] = 16'h0000;
    $display("type table test done");
  endtask : test_types

  task automatic test_special;
    do_reset();
    wr_type(1, 5'h0c);
    check(type_q[1], 5'h02);
    wr_type(1, 5'h12);
    check(type_q[1], 5'h02);
    wr_type(0, 5'h0c);
    check(type_q[0], 5'h0c);
    wr_type(2, 5'h0d);
    check(type_q[2], 5'h0d);
    loop_break_alarm = 1'b1;
    rate_alarm = 1'b1;
    settle();
    check(alarm_out_q[0], 1'b1);
    check(alarm_out_q[2], 1'b1);
    loop_break_alarm = 1'b0;
    rate_alarm = 1'b0;
    do_reset();
    heater_variant = 1'b1;
    wr_type(0, 5'h08);
    check(type_q[0], 5'h02);
    heater_alarm = 1'b1;
    tick(3);
    check(alarm_out_q[0], 1'b1);
    heater_alarm = 1'b0;
    tick(3);
    check(alarm_out_q[0], 1'b0);
    assign_alarm1 = 1'b1;
    wr_type(0, 5'h08);
    check(type_q[0], 5'h08);
    heater_variant = 1'b0;
    assign_alarm1 = 1'b0;
    $display("special type test done");
  endtask : test_special

  task automatic test_hys_delay;
    do_reset();
    wr_type(1, 5'h08);
    alarm_value[1] = 16'h001e;
    hysteresis[1] = 16'h0005;
    proc_next = 16'h001f;
    settle();
    check(alarm_out_q[1], 1'b1);
    proc_next = 16'h001c;
    settle();
    check(alarm_out_q[1], 1'b1);
    proc_next = 16'h0019;
    settle();
    check(alarm_out_q[1], 1'b0);
    hysteresis[1] = 16'h0000;
    on_delay[1] = 10'h002;
    off_delay[1] = 10'h002;
    proc_next = 16'h001f;
    tick(150);
    check(alarm_out_q[1], 1'b0);
    tick(300);
    check(alarm_out_q[1], 1'b1);
    proc_next = 16'h0000;
    tick(150);
    check(alarm_out_q[1], 1'b1);
    tick(300);
    check(alarm_out_q[1], 1'b0);
    $display("hysteresis and delay test done");
  endtask : test_hys_delay

  initial begin
    do_reset();
    test_reset_strobe();
    test_types();
    sb_case(5'h05, 16'h0064, 16'h0032, 16'h0000);
    sb_case(5'h06, 16'h003c, 16'h0032, 16'h000a);
    sb_case(5'h07, 16'h0028, 16'h0032, 16'h000a);
    sb_case(5'h0a, 16'h001f, 16'h0000, 16'h001e);
    sb_case(5'h0b, 16'h001d, 16'h0032, 16'h001e);
    test_special();
    test_hys_delay();
    close_out();
  end
endmodule : test_process_alarm_evaluator
